// >>> pkg/lpwc_defines.vh
/*
 Constants for the low-power mode and wake-up control block: mode codes,
 source counts, oscillator rates and the reset value of the retained file.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef LPWC_DEFINES_VH
`define LPWC_DEFINES_VH

// Requested device modes.
`define LPWC_MODE_W       3
`define LPWC_MODE_RUN     3'h0
`define LPWC_MODE_STOP    3'h1
`define LPWC_MODE_VERY_LOW_POWER_STOP    3'h2
`define LPWC_MODE_LLS     3'h3
`define LPWC_MODE_LEAKAGE_STOP_LEVEL_THREE   3'h4
`define LPWC_MODE_LEAKAGE_STOP_LEVEL_ONE   3'h5
`define LPWC_MODE_LEAKAGE_STOP_LEVEL_ZERO   3'h6

// Wake-up sources: external pins then internal modules.
`define LPWC_EXT_PINS     8
`define LPWC_INT_MODS     4
`define LPWC_SRC_W        12

// Oscillator rates in kHz.
`define LPWC_FAST_OSC_KHZ 48000
`define LPWC_SLOW_HI_KHZ  8000
`define LPWC_SLOW_LO_KHZ  2000
`define LPWC_LPO_KHZ      1

// Retained system register file: 32 bytes.
`define LPWC_SRF_BYTES    32
`define LPWC_SRF_AW       5
`define LPWC_SRF_RESET    8'h00

`endif

// >>> rtl/lpwc_wake_detect.v
/*
 Wake-up detector: latches which enabled source fired while armed and holds
 the flags until acknowledged.
 Assumes sources are synchronous to CLK and already edge-qualified upstream.
*/
`timescale 1ns/1ns
`include "lpwc_defines.vh"

module lpwc_wake_detect (
	input  wire                     clk,        // System clock.
	input  wire                     reset_n,    // Asynchronous reset, active low.
	input  wire                     armed,      // Detection allowed this cycle.
	input  wire [`LPWC_SRC_W-1:0]   sources,    // Raw wake sources.
	input  wire [`LPWC_SRC_W-1:0]   enables,    // Per-source enables.
	input  wire                     ack,        // Software acknowledge pulse.
	output wire [`LPWC_SRC_W-1:0]   flags,      // Recorded sources, value for the coming edge.
	output wire                     hit         // A new wake event this cycle.
);

	reg [`LPWC_SRC_W-1:0] flag_reg;
	reg [`LPWC_SRC_W-1:0] flag_next;
	wire [`LPWC_SRC_W-1:0] evt;

	assign evt = armed ? (sources & enables) : {`LPWC_SRC_W{1'b0}};
	assign hit = |evt;
	// The parent registers this, so its output shows an event on the edge that takes it.
	assign flags = flag_next;

	// A new event wins over an acknowledge in the same cycle so none is lost.
	always @* begin
		flag_next = ack ? {`LPWC_SRC_W{1'b0}} : flag_reg;
		flag_next = flag_next | evt;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_reg <= {`LPWC_SRC_W{1'b0}};
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule // lpwc_wake_detect

// >>> rtl/lpwc_top.v
/*
 Low-power mode sequencer and leakage wake-up control: tracks the stop-class
 mode, arms the wake-up detector, steers retention, oscillator and
 peripheral-domain controls, and picks the boot vector base.
 Assumes all inputs synchronous to CLK and a power-on reset on RESET_N.
*/
// Functional notes
// - Wake unit active in leakage stops and after deep wake until acknowledged.
// - Leaving low-leakage stop disables wake unit immediately.
// - After very-low-leakage stop, detect until acknowledged.
// - Eight pins and four modules wake.
// - Stop keeps registers, SRAM, voltage detect; async wake.
// - Very-low-power stop keeps SRAM; detect, controller off.
// - Low-leakage stop keeps SRAM, register file, programming.
// - Low-leakage stop holds outputs and reference static.
// - Very-low-leakage stop powers off, peripherals restart reset.
// - Wake unit, timer, clock alive in deep stops.
// - Level three keeps SRAM, file, comparator, outputs.
// - Level one keeps file only, comparator, power.
// - Level zero keeps file; power-on detect selectable.
// - Slow oscillator 8/2 MHz, default 8, off deep.
// - Low-power oscillator 1 kHz, off at level zero.
// - Fast oscillator gives 48 MHz.
// - Blank part boots ROM, else flash vectors.
// - Real-time clock reset by power-on or software.
`timescale 1ns/1ns
`include "lpwc_defines.vh"

module lpwc_top (
	input  wire                       CLK,              // 100 MHz system clock.
	input  wire                       RESET_N,          // Power-on reset, active low.
	input  wire                       STOP_REQ,         // Pulse: enter MODE_SEL.
	input  wire [`LPWC_MODE_W-1:0]    MODE_SEL,         // Stop mode to enter.
	input  wire                       POR_DET_EN,       // Power-on detect kept in level zero.
	input  wire                       INT_PENDING,      // Interrupt request for async wake.
	input  wire [`LPWC_EXT_PINS-1:0]  WAKE_PINS,        // External wake pins.
	input  wire [`LPWC_INT_MODS-1:0]  WAKE_MODS,        // Internal module wake outputs.
	input  wire [`LPWC_SRC_W-1:0]     WAKE_EN,          // Per-source wake enables.
	input  wire                       WAKE_ACK,         // Pulse: software acknowledges wake.
	input  wire                       SLOW_OSC_LO,      // Select 2 MHz slow oscillator.
	input  wire                       FLASH_BLANK,      // Boot options show blank device.
	input  wire                       RTC_SW_RESET,     // Software reset of real-time clock.
	input  wire                       SRF_WE,           // Retained register file write.
	input  wire [`LPWC_SRF_AW-1:0]    SRF_ADDR,         // Register file byte index.
	input  wire [7:0]                 SRF_WDATA,        // Register file write data.
	output reg  [7:0]                 SRF_RDATA,        // Register file read data.
	output reg  [`LPWC_MODE_W-1:0]    MODE_STATE,       // Current device mode.
	output reg                        WAKE_ACTIVE,      // Wake-up unit detecting.
	output reg  [`LPWC_SRC_W-1:0]     WAKE_FLAGS,       // Recorded wake sources.
	output reg                        SRAM_RETAIN,      // SRAM powered.
	output reg                        REGS_RETAIN,      // All registers retained.
	output reg                        LVD_ON,           // Low-voltage detect on.
	output reg                        NESTED_INTERRUPT_CONTROLLER_ON,          // Interrupt controller clocked.
	output reg                        ASYNC_WAKEUP_INTERRUPT_LOGIC_ON,          // Async wake interrupt logic armed.
	output reg                        PERIPH_STATIC,    // Peripherals frozen with programming.
	output reg                        PERIPH_PWR,       // Peripheral domain powered.
	output reg                        PERIPH_RESET,     // Peripheral restart from reset.
	output reg                        GPIO_HOLD,        // Pin outputs latched at last value.
	output reg                        CMP_ON,           // Low-speed comparator on.
	output reg                        PMC_ON,           // Power management on.
	output reg                        POR_DET_ON,       // Power-on detect on.
	output reg                        LOW_POWER_TIMER_RTC_ON,     // Low-power timer and RTC on.
	output reg                        SLOW_OSC_ON,      // Slow oscillator available.
	output reg                        SLOW_OSC_8M,      // Slow oscillator at 8 MHz.
	output reg                        LPO_ON,           // 1 kHz oscillator available.
	output reg                        FAST_OSC_ON,      // 48 MHz oscillator on.
	output reg                        BOOT_ROM,         // Vector table at ROM base.
	output reg                        RTC_RESET         // Reset to real-time clock.
);

	localparam S_RUN   = 3'h0;
	localparam S_STOP  = 3'h1;
	localparam S_VERY_LOW_POWER_STOP  = 3'h2;
	localparam S_LLS   = 3'h3;
	localparam S_LEAKAGE_STOP_LEVEL_THREE = 3'h4;
	localparam S_LEAKAGE_STOP_LEVEL_ONE = 3'h5;
	localparam S_LEAKAGE_STOP_LEVEL_ZERO = 3'h6;
	localparam S_WAKE  = 3'h7;

	reg  [2:0]                state_reg;
	reg  [2:0]                state_next;
	reg                       deep_latch_reg;
	reg                       deep_latch_next;
	reg                       por_sel_reg;
	reg  [`LPWC_MODE_W-1:0]   resume_reg;
	reg  [7:0]                srf_mem [0:`LPWC_SRF_BYTES-1];
	wire [`LPWC_SRC_W-1:0]    all_src;
	wire [`LPWC_SRC_W-1:0]    flags;
	wire                      wake_hit;
	wire                      armed;
	integer                   i;

	// True for the low-leakage and very-low-leakage states.
	function is_leak;
		input [2:0] s;
		begin
			is_leak = (s == S_LLS) || (s == S_LEAKAGE_STOP_LEVEL_THREE) || (s == S_LEAKAGE_STOP_LEVEL_ONE) || (s == S_LEAKAGE_STOP_LEVEL_ZERO);
		end
	endfunction

	// True for the very-low-leakage states only.
	function is_very_low_leakage_stop;
		input [2:0] s;
		begin
			is_very_low_leakage_stop = (s == S_LEAKAGE_STOP_LEVEL_THREE) || (s == S_LEAKAGE_STOP_LEVEL_ONE) || (s == S_LEAKAGE_STOP_LEVEL_ZERO);
		end
	endfunction

	assign all_src = {WAKE_MODS, WAKE_PINS};
	// Armed in leakage stops and after deep wake until acknowledged.
	assign armed = is_leak(state_reg) || deep_latch_reg;

	lpwc_wake_detect u_detect (
		.clk     (CLK),
		.reset_n (RESET_N),
		.armed   (armed),
		.sources (all_src),
		.enables (WAKE_EN),
		.ack     (WAKE_ACK),
		.flags   (flags),
		.hit     (wake_hit)
	);

	// Mode sequencing. Stop and very-low-power stop wake on interrupts
	// through async logic; leakage stops wake through the detector.
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_RUN: begin
				if (STOP_REQ) begin
					case (MODE_SEL)
						`LPWC_MODE_STOP:  state_next = S_STOP;
						`LPWC_MODE_VERY_LOW_POWER_STOP:  state_next = S_VERY_LOW_POWER_STOP;
						`LPWC_MODE_LLS:   state_next = S_LLS;
						`LPWC_MODE_LEAKAGE_STOP_LEVEL_THREE: state_next = S_LEAKAGE_STOP_LEVEL_THREE;
						`LPWC_MODE_LEAKAGE_STOP_LEVEL_ONE: state_next = S_LEAKAGE_STOP_LEVEL_ONE;
						`LPWC_MODE_LEAKAGE_STOP_LEVEL_ZERO: state_next = S_LEAKAGE_STOP_LEVEL_ZERO;
						default:          state_next = S_RUN;
					endcase
				end
			end
			S_STOP, S_VERY_LOW_POWER_STOP: begin
				if (INT_PENDING || wake_hit) begin
					state_next = S_RUN;
				end
			end
			S_LLS, S_LEAKAGE_STOP_LEVEL_THREE, S_LEAKAGE_STOP_LEVEL_ONE, S_LEAKAGE_STOP_LEVEL_ZERO: begin
				if (wake_hit) begin
					state_next = is_very_low_leakage_stop(state_reg) ? S_WAKE : S_RUN;
				end
			end
			S_WAKE: state_next = S_RUN;
			default: state_next = S_RUN;
		endcase
	end

	// Detection persists after a deep wake until acknowledged; an event in
	// the acknowledge cycle is still caught by the detector itself. The latch
	// sets on the edge into the wake cycle so detection has no gap there.
	always @* begin
		deep_latch_next = deep_latch_reg;
		if (state_next == S_WAKE || state_reg == S_WAKE) begin
			deep_latch_next = 1'b1;
		end else if (WAKE_ACK) begin
			deep_latch_next = 1'b0;
		end
		if (state_reg == S_LLS && state_next == S_RUN) begin
			deep_latch_next = 1'b0;
		end
	end

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg      <= S_RUN;
			deep_latch_reg <= 1'b0;
			por_sel_reg    <= 1'b1;
			resume_reg     <= `LPWC_MODE_RUN;
		end else begin
			state_reg      <= state_next;
			deep_latch_reg <= deep_latch_next;
			if (state_reg == S_RUN && STOP_REQ) begin
				por_sel_reg <= POR_DET_EN;
				resume_reg  <= MODE_SEL;
			end
		end
	end

	// Retained register file. It survives every stop, so it has no reset
	// path besides the power-on reset.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (i = 0; i < `LPWC_SRF_BYTES; i = i + 1) begin
				srf_mem[i] <= `LPWC_SRF_RESET;
			end
			SRF_RDATA <= `LPWC_SRF_RESET;
		end else begin
			if (SRF_WE && state_reg == S_RUN) begin
				srf_mem[SRF_ADDR] <= SRF_WDATA;
			end
			SRF_RDATA <= srf_mem[SRF_ADDR];
		end
	end

	// Domain controls, registered so they never glitch into power switches.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MODE_STATE    <= `LPWC_MODE_RUN;
			WAKE_ACTIVE   <= 1'b0;
			WAKE_FLAGS    <= {`LPWC_SRC_W{1'b0}};
			SRAM_RETAIN   <= 1'b1;
			REGS_RETAIN   <= 1'b1;
			LVD_ON        <= 1'b1;
			NESTED_INTERRUPT_CONTROLLER_ON       <= 1'b1;
			ASYNC_WAKEUP_INTERRUPT_LOGIC_ON       <= 1'b0;
			PERIPH_STATIC <= 1'b0;
			PERIPH_PWR    <= 1'b1;
			PERIPH_RESET  <= 1'b0;
			GPIO_HOLD     <= 1'b0;
			CMP_ON        <= 1'b1;
			PMC_ON        <= 1'b1;
			POR_DET_ON    <= 1'b1;
			LOW_POWER_TIMER_RTC_ON  <= 1'b1;
			SLOW_OSC_ON   <= 1'b1;
			SLOW_OSC_8M   <= 1'b1;
			LPO_ON        <= 1'b1;
			FAST_OSC_ON   <= 1'b1;
			BOOT_ROM      <= 1'b0;
			RTC_RESET     <= 1'b1;
		end else begin
			MODE_STATE    <= (state_next == S_WAKE) ? `LPWC_MODE_RUN : state_next;
			WAKE_ACTIVE   <= is_leak(state_next) || deep_latch_next;
			WAKE_FLAGS    <= flags;
			SRAM_RETAIN   <= !(state_next == S_LEAKAGE_STOP_LEVEL_ONE || state_next == S_LEAKAGE_STOP_LEVEL_ZERO);
			REGS_RETAIN   <= !is_very_low_leakage_stop(state_next);
			LVD_ON        <= !(state_next == S_VERY_LOW_POWER_STOP) && !is_leak(state_next);
			NESTED_INTERRUPT_CONTROLLER_ON       <= (state_next == S_RUN) || (state_next == S_WAKE);
			ASYNC_WAKEUP_INTERRUPT_LOGIC_ON       <= (state_next == S_STOP) || (state_next == S_VERY_LOW_POWER_STOP);
			PERIPH_STATIC <= (state_next == S_LLS);
			PERIPH_PWR    <= !is_very_low_leakage_stop(state_next);
			PERIPH_RESET  <= (state_next == S_WAKE);
			GPIO_HOLD     <= is_leak(state_next);
			CMP_ON        <= (state_next != S_LEAKAGE_STOP_LEVEL_ZERO);
			PMC_ON        <= 1'b1;
			POR_DET_ON    <= (state_next == S_LEAKAGE_STOP_LEVEL_ZERO) ? ((state_reg == S_RUN) ? POR_DET_EN : por_sel_reg) : 1'b1;
			LOW_POWER_TIMER_RTC_ON  <= 1'b1;
			SLOW_OSC_ON   <= !is_very_low_leakage_stop(state_next);
			SLOW_OSC_8M   <= !SLOW_OSC_LO;
			LPO_ON        <= (state_next != S_LEAKAGE_STOP_LEVEL_ZERO);
			FAST_OSC_ON   <= (state_next == S_RUN) || (state_next == S_WAKE);
			BOOT_ROM      <= FLASH_BLANK;
			RTC_RESET     <= RTC_SW_RESET;
		end
	end

endmodule // lpwc_top

// >>> dv/lpwc_asserts.sv
/*
 Checker for the low-power mode and wake-up block, bound to lpwc_top.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ns

module lpwc_asserts (
	input wire        CLK,          // System clock.
	input wire        RESET_N,      // Reset, active low.
	input wire        STOP_REQ,     // Mode request.
	input wire        WAKE_ACK,     // Wake acknowledge.
	input wire [2:0]  MODE_STATE,   // Current mode.
	input wire        WAKE_ACTIVE,  // Detector armed.
	input wire [11:0] WAKE_FLAGS,   // Recorded sources.
	input wire        PERIPH_RESET, // Restart pulse.
	input wire        REGS_RETAIN,  // Registers kept.
	input wire        LVD_ON,       // Voltage detect.
	input wire        NESTED_INTERRUPT_CONTROLLER_ON,      // Controller on.
	input wire        ASYNC_WAKEUP_INTERRUPT_LOGIC_ON,      // Async wake on.
	input wire        CMP_ON,       // Comparator on.
	input wire        LOW_POWER_TIMER_RTC_ON, // Timer and clock on.
	input wire        SLOW_OSC_ON,  // Slow oscillator.
	input wire        LPO_ON        // 1 kHz oscillator.
);
	// All checks share the one clock, and reset silences them.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// Mode outputs and the wake detector against the mode held.
	property p_stop_idle; (MODE_STATE == 3'h1 || MODE_STATE == 3'h2) |-> !WAKE_ACTIVE; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("Wake unit armed in stop.");
	property p_lls_exit; $past(MODE_STATE) == 3'h3 && MODE_STATE == 3'h0 |-> !WAKE_ACTIVE; endproperty
	a_lls_exit: assert property (p_lls_exit) else $error("Wake unit kept after lls.");
	property p_deep_hold; MODE_STATE == 3'h0 && WAKE_ACTIVE && !WAKE_ACK && !STOP_REQ |=> WAKE_ACTIVE; endproperty
	a_deep_hold: assert property (p_deep_hold) else $error("Wake unit dropped before ack.");
	property p_flag_hold; MODE_STATE == 3'h0 && !WAKE_ACTIVE && !WAKE_ACK && !STOP_REQ |=> $stable(WAKE_FLAGS);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("Wake flags moved without ack.");
	property p_restart; $past(MODE_STATE) >= 3'h4 && MODE_STATE == 3'h0 |-> PERIPH_RESET ##1 !PERIPH_RESET;
	endproperty
	a_restart: assert property (p_restart) else $error("No restart pulse on deep wake.");
	property p_stop_keep; MODE_STATE == 3'h1 |-> REGS_RETAIN && LVD_ON && ASYNC_WAKEUP_INTERRUPT_LOGIC_ON && !NESTED_INTERRUPT_CONTROLLER_ON; endproperty
	a_stop_keep: assert property (p_stop_keep) else $error("Stop retention wrong.");
	property p_deep_osc; MODE_STATE >= 3'h4 |-> !SLOW_OSC_ON && LOW_POWER_TIMER_RTC_ON && WAKE_ACTIVE; endproperty
	a_deep_osc: assert property (p_deep_osc) else $error("Deep stop domains wrong.");
	property p_lvl0; MODE_STATE == 3'h6 |-> !LPO_ON && !CMP_ON; endproperty
	a_lvl0: assert property (p_lvl0) else $error("Level zero clocks wrong.");
endmodule // lpwc_asserts

bind lpwc_top lpwc_asserts u_chk (.*);

// >>> dv/lpwc_wake_src.sv
/*
 Wake-source model: raises one of twelve wake sources and holds it.
 Assumes commands change just after the clock edge.
*/
`timescale 1ns/1ns

module lpwc_wake_src (
	input  wire       clk,  // System clock.
	input  wire       fire, // Raise source idx.
	input  wire [3:0] idx,  // Source index, pins first.
	input  wire       clr,  // Release all sources.
	output reg  [7:0] pins, // External wake pins.
	output reg  [3:0] mods  // Module wake outputs.
);
	// Sources idle low; a raised source stays a level until released.
	initial {mods, pins} = 12'h000;
	// One-hot over the eight pins and the four modules.
	always @(posedge clk) begin
		if (clr)
			{mods, pins} <= 12'h000;
		else if (fire)
			{mods, pins} <= 12'h001 << idx;
	end
endmodule // lpwc_wake_src

// >>> dv/lpwc_top_tb.sv
/*
 Self-checking bench for lpwc_top with the wake-source model.
 Assumes the design, checker and model files are compiled first.
*/
`timescale 1ns/1ns

module lpwc_top_tb;
	reg         CLK, RESET_N, STOP_REQ, POR_DET_EN, INT_PENDING, WAKE_ACK, fire, clr;
	reg         SLOW_OSC_LO, FLASH_BLANK, RTC_SW_RESET, SRF_WE;
	reg  [2:0]  MODE_SEL;
	reg  [3:0]  idx;
	reg  [11:0] WAKE_EN;
	reg  [4:0]  SRF_ADDR;
	reg  [7:0]  SRF_WDATA;
	wire [7:0]  SRF_RDATA, WAKE_PINS;
	wire [3:0]  WAKE_MODS;
	wire [2:0]  MODE_STATE;
	wire [11:0] WAKE_FLAGS;
	wire WAKE_ACTIVE, SRAM_RETAIN, REGS_RETAIN, LVD_ON, NESTED_INTERRUPT_CONTROLLER_ON, ASYNC_WAKEUP_INTERRUPT_LOGIC_ON, PERIPH_STATIC, PERIPH_PWR;
	wire PERIPH_RESET, GPIO_HOLD, CMP_ON, PMC_ON, POR_DET_ON, LOW_POWER_TIMER_RTC_ON, SLOW_OSC_ON, SLOW_OSC_8M;
	wire LPO_ON, FAST_OSC_ON, BOOT_ROM, RTC_RESET;
	int err_count, n_tests;

	lpwc_top u_dut (.*);
	lpwc_wake_src u_src (.clk(CLK), .fire(fire), .idx(idx), .clr(clr), .pins(WAKE_PINS), .mods(WAKE_MODS));

	// 100 MHz clock.
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// Inputs move 1 ns after the edge so the design never races the bench.
	task cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task go(input [2:0] m);
		MODE_SEL = m;
		STOP_REQ = 1'b1;
		cyc(1);
		STOP_REQ = 1'b0;
	endtask
	task raise(input [3:0] i);
		idx = i;
		fire = 1'b1;
		cyc(1);
		fire = 1'b0;
	endtask
	// Bounded wait for the return to run.
	task wait_run;
		int k;
		k = 0;
		while (MODE_STATE !== 3'h0 && k < 20) begin
			cyc(1);
			k++;
		end
		chk(k < 20, 1'b1);
	endtask
	// Sources are released before the ack, since a live source would win over it.
	task ack(input act);
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(2);
		chk(WAKE_ACTIVE, act);
		WAKE_ACK = 1'b1;
		cyc(1);
		WAKE_ACK = 1'b0;
		chk(WAKE_ACTIVE, 1'b0);
		chk(WAKE_FLAGS, 12'h000);
	endtask

	task t_lls;
		WAKE_EN = 12'hFDF;
		go(3'h3);
		chk({WAKE_ACTIVE, GPIO_HOLD, PERIPH_STATIC, SRAM_RETAIN}, 4'hF);
		raise(4'h5);
		cyc(4);
		chk(MODE_STATE, 3'h3);
		WAKE_EN = 12'hFFF;
		wait_run;
		chk(WAKE_FLAGS, 12'h020);
		ack(1'b0);
		$display("lls test done");
	endtask
	task t_deep(input [2:0] m, input [3:0] i);
		POR_DET_EN = i[0];
		go(m);
		chk({SRAM_RETAIN, CMP_ON, LPO_ON, PMC_ON, LOW_POWER_TIMER_RTC_ON, PERIPH_PWR, SLOW_OSC_ON},
			{m == 3'h4, m != 3'h6, m != 3'h6, 4'hC});
		chk(POR_DET_ON, m == 3'h6 ? i[0] : 1'b1);
		raise(i);
		wait_run;
		chk(PERIPH_RESET, 1'b1);
		chk(WAKE_ACTIVE, 1'b1);
		chk(WAKE_FLAGS, 12'h001 << i);
		ack(1'b1);
		$display("deep test %0d done", m);
	endtask
	task t_stop(input [2:0] m);
		go(m);
		chk({WAKE_ACTIVE, NESTED_INTERRUPT_CONTROLLER_ON, ASYNC_WAKEUP_INTERRUPT_LOGIC_ON, LVD_ON, SRAM_RETAIN}, {3'h1, m == 3'h1, 1'b1});
		INT_PENDING = 1'b1;
		wait_run;
		INT_PENDING = 1'b0;
		$display("stop test %0d done", m);
	endtask
	task t_misc;
		go(3'h0);
		chk(MODE_STATE, 3'h0);
		go(3'h7);
		chk(MODE_STATE, 3'h0);
		{FLASH_BLANK, SLOW_OSC_LO, RTC_SW_RESET} = 3'h7;
		cyc(2);
		chk({BOOT_ROM, SLOW_OSC_8M, RTC_RESET}, 3'h5);
		{FLASH_BLANK, SLOW_OSC_LO, RTC_SW_RESET} = 3'h0;
		cyc(2);
		chk({BOOT_ROM, SLOW_OSC_8M, RTC_RESET}, 3'h2);
		$display("misc test done");
	endtask

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Reset, retained-file write, then the scenarios.
	initial begin
		{RESET_N, STOP_REQ, POR_DET_EN, INT_PENDING, WAKE_ACK, fire, clr, SLOW_OSC_LO} = 8'h00;
		{FLASH_BLANK, RTC_SW_RESET, SRF_WE, MODE_SEL, idx, SRF_ADDR, SRF_WDATA} = 24'h000000;
		WAKE_EN = 12'hFFF;
		cyc(3);
		chk({MODE_STATE, RTC_RESET}, 4'h1);
		cyc(3);
		RESET_N = 1'b1;
		cyc(1);
		chk({SLOW_OSC_8M, FAST_OSC_ON, SLOW_OSC_ON}, 3'h7);
		{SRF_WE, SRF_ADDR, SRF_WDATA} = 14'h3FA5;
		cyc(1);
		SRF_WE = 1'b0;
		t_lls;
		t_deep(3'h4, 4'hB);
		t_deep(3'h5, 4'h8);
		t_deep(3'h6, 4'h2);
		t_deep(3'h6, 4'h9);
		cyc(1);
		chk(SRF_RDATA, 8'hA5);
		t_stop(3'h1);
		t_stop(3'h2);
		t_misc;
		final_report;
	end

	// Hang guard: the scenarios need well under a thousand cycles.
	initial begin
		#200000;
		err_count++;
		final_report;
	end
endmodule // lpwc_top_tb
